// file: logic/lpmc_top.sv
// Low-power mode controller: mode state machine, clock enables, pin holding.
// Assumes an AXI4-Lite master, a one-cycle halt pulse from the CPU and
// priority-qualified interrupt requests on the same clock.
// Notes on behaviour
// - Wait with gating set stops peripheral clocks; sub timer clock keeps running.
// - Halt instruction enters wait mode and stops the CPU clock.
// - Wait in bus modes holds bus and ports, drives strobes high.
// - Wait: clock output toggles on sub clock; divided clock holds if gated.
// - Reset, non-maskable or enabled peripheral interrupt ends wait mode.
// - With gating on, only externally clocked peripherals wake; converter never.
// - With gating off, converter wakes only in single modes; timers always.
// - Wait exit restores the same CPU clock source and divider.
// - Stop turns off all oscillators, CPU and peripheral clocks.
// - Only NMI, key, pin, event timer, external serial, CAN wake end stop.
// - Writing all-clocks-off enters stop, forcing divide-by-eight and high drive.
// - Stop holds bus pins as wait; clock output high on sub, else held.
// - Stop exit returns to sub clock, or main/ring divided by eight.
// - PLL mode only to and from high-speed; no wait or stop from PLL.
// - Ring may run in low-speed; sub clock may run in PLL mode.
// - No direct change between sub-clock modes and ring oscillator modes.
// - Leaving stop forces divide-by-eight.
`timescale 1ns/100ps
module lpmc_top import lpmc_pkg::*; (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  output logic [1:0]             s_axi_bresp_o,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  input  wire logic [ADDR_W-1:0] s_axi_araddr_i,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  input  wire logic              halt_i,
  input  wire lpmc_pins_t        pins_i,
  input  wire lpmc_periph_t      irq_i,
  input  wire lpmc_cfg_t         pcfg_i,
  input  wire logic              clock_output_pin_src_i,
  output lpmc_clk_t              clk_o,
  output logic                   div8_o,
  output logic [1:0]             div_sel_o,
  output logic                   high_drive_o,
  output logic                   bus_hold_o,
  output logic                   strobe_high_o,
  output logic                   clock_output_pin_o
);

  function automatic logic [1:0] reg_sel(input logic [ADDR_W-1:0] a);
    if (a == CTRL_OFF) reg_sel = SEL_CTRL;
    else if (a == MODE_OFF) reg_sel = SEL_MODE;
    else if (a == STAT_OFF) reg_sel = SEL_STAT;
    else reg_sel = SEL_NONE;
  endfunction : reg_sel

  function automatic logic allowed(input lpmc_state_t cur, input lpmc_state_t tgt,
                                   input logic sub_on, input logic pll_en,
                                   input logic div8);
    allowed = 1'b0;
    case (cur)
      ST_HIGH: allowed = (tgt == ST_HIGH) || (tgt == ST_RING) ||
                         (tgt == ST_PLL && pll_en) || (tgt == ST_LOW && sub_on);
      ST_LOW:  allowed = (tgt == ST_LOW) || (tgt == ST_HIGH) || (tgt == ST_LPWR);
      ST_LPWR: allowed = (tgt == ST_LPWR) || (tgt == ST_LOW);
      ST_PLL:  allowed = (tgt == ST_PLL) || (tgt == ST_HIGH);
      ST_RING: allowed = (tgt == ST_RING) || (tgt == ST_RLP) || (tgt == ST_HIGH && div8);
      ST_RLP:  allowed = (tgt == ST_RLP) || (tgt == ST_RING);
      default: allowed = 1'b0;
    endcase
  endfunction : allowed

  lpmc_pins_t pins_s;
  logic       clk_src_s;
  logic       wait_wake;
  logic       stop_wake;

  lpmc_sync #(.W(4)) u_sync (
    .clk_i   (clk_i),
    .rst_n_i (rst_n_i),
    .d_i     ({pins_i, clock_output_pin_src_i}),
    .q_o     ({pins_s, clk_src_s})
  );

  // AXI4-Lite slave
  logic              aw_open, w_open, ar_open;
  logic              next_aw_open, next_w_open, next_ar_open;
  logic [ADDR_W-1:0] aw_addr, next_aw_addr;
  logic [15:0]       w_data, next_w_data;
  logic [1:0]        w_strb, next_w_strb;
  logic              next_bvalid, next_rvalid;
  logic [1:0]        next_bresp, next_rresp;
  logic [31:0]       next_rdata;
  logic              wr_fire;

  logic [CTRL_W-1:0] ctrl, next_ctrl;
  lpmc_state_t       state, next_state, saved, next_saved;
  logic              err, next_err;

  assign wr_fire = !aw_open && !w_open && !s_axi_bvalid_o;

  always_comb begin
    next_aw_open = aw_open;
    next_w_open  = w_open;
    next_ar_open = ar_open;
    next_aw_addr = aw_addr;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid_o;
    next_bresp   = s_axi_bresp_o;
    next_rvalid  = s_axi_rvalid_o;
    next_rresp   = s_axi_rresp_o;
    next_rdata   = s_axi_rdata_o;
    if (s_axi_awvalid_i && aw_open) begin
      next_aw_open = 1'b0;
      next_aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && w_open) begin
      next_w_open = 1'b0;
      next_w_data = s_axi_wdata_i[15:0];
      next_w_strb = s_axi_wstrb_i[1:0];
    end
    if (wr_fire) begin
      next_bvalid = 1'b1;
      next_bresp  = (reg_sel(aw_addr) == SEL_NONE) ? RESP_SLVERR : RESP_OKAY;
    end else if (s_axi_bvalid_o && s_axi_bready_i) begin
      next_bvalid  = 1'b0;
      next_aw_open = 1'b1;
      next_w_open  = 1'b1;
    end
    if (s_axi_arvalid_i && ar_open) begin
      next_ar_open = 1'b0;
      next_rvalid  = 1'b1;
      next_rresp   = RESP_OKAY;
      next_rdata   = 32'h0000_0000;
      case (reg_sel(s_axi_araddr_i))
        SEL_CTRL: next_rdata[CTRL_W-1:0] = ctrl & ~(16'h0001 << B_ACO);
        SEL_MODE: next_rdata[2:0] = state;
        SEL_STAT: next_rdata[B_ERR:0] = {err, 1'b0, state};
        default:  next_rresp = RESP_SLVERR;
      endcase
    end else if (s_axi_rvalid_o && s_axi_rready_i) begin
      next_rvalid  = 1'b0;
      next_ar_open = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      aw_open        <= 1'b1;
      w_open         <= 1'b1;
      ar_open        <= 1'b1;
      aw_addr        <= '0;
      w_data         <= 16'h0000;
      w_strb         <= 2'h0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= RESP_OKAY;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rresp_o  <= RESP_OKAY;
      s_axi_rdata_o  <= 32'h0000_0000;
    end else begin
      aw_open        <= next_aw_open;
      w_open         <= next_w_open;
      ar_open        <= next_ar_open;
      aw_addr        <= next_aw_addr;
      w_data         <= next_w_data;
      w_strb         <= next_w_strb;
      s_axi_bvalid_o <= next_bvalid;
      s_axi_bresp_o  <= next_bresp;
      s_axi_rvalid_o <= next_rvalid;
      s_axi_rresp_o  <= next_rresp;
      s_axi_rdata_o  <= next_rdata;
    end
  end

  assign s_axi_awready_o = aw_open;
  assign s_axi_wready_o  = w_open;
  assign s_axi_arready_o = ar_open;

  lpmc_wake u_wake (
    .pins_i      (pins_s),
    .irq_i       (irq_i),
    .cfg_i       (pcfg_i),
    .gate_i      (ctrl[B_GATE]),
    .wait_wake_o (wait_wake),
    .stop_wake_o (stop_wake)
  );

  // Mode state machine
  logic        wr_ctrl, wr_mode, wr_stat, stop_req;
  logic [15:0] merged;
  lpmc_state_t tgt;

  assign wr_ctrl  = wr_fire && reg_sel(aw_addr) == SEL_CTRL;
  assign wr_mode  = wr_fire && reg_sel(aw_addr) == SEL_MODE && w_strb[0];
  assign wr_stat  = wr_fire && reg_sel(aw_addr) == SEL_STAT && w_strb[0];
  assign stop_req = wr_ctrl && w_strb[0] && w_data[B_ACO];
  assign merged   = {w_strb[1] ? w_data[15:8] : ctrl[15:8],
                     w_strb[0] ? w_data[7:0] : ctrl[7:0]};
  assign tgt      = lpmc_state_t'(w_data[2:0]);

  always_comb begin
    next_ctrl  = ctrl;
    next_state = state;
    next_saved = saved;
    next_err   = err;
    if (wr_ctrl) next_ctrl = (merged & CTRL_WMASK) | (ctrl & ~CTRL_WMASK);
    if (wr_stat && w_data[B_ERR]) next_err = 1'b0;
    case (state)
      ST_WAIT: begin
        if (wait_wake) next_state = saved;
      end
      ST_STOP: begin
        if (stop_wake) begin
          if (saved == ST_LOW || saved == ST_LPWR) next_state = saved;
          else if (saved == ST_RING || saved == ST_RLP) next_state = ST_RING;
          else next_state = ST_HIGH;
          next_ctrl[B_DIV8] = 1'b1;
        end
      end
      default: begin
        if (halt_i) begin
          if (state == ST_PLL) next_err = 1'b1;
          else begin
            next_saved = state;
            next_state = ST_WAIT;
          end
        end else if (stop_req) begin
          if (state == ST_PLL) next_err = 1'b1;
          else begin
            next_saved        = state;
            next_state        = ST_STOP;
            next_ctrl[B_DIV8] = 1'b1;
            next_ctrl[B_HDRV] = 1'b1;
          end
        end else if (wr_mode) begin
          if (allowed(state, tgt, ctrl[B_SUBON], ctrl[B_PLLEN], ctrl[B_DIV8])) begin
            next_state = tgt;
            if (tgt == ST_LPWR) next_ctrl[B_DIV8] = 1'b1;
          end else next_err = 1'b1;
        end
      end
    endcase
    next_ctrl[B_PLLSEL] = (next_state == ST_PLL);
    next_ctrl[B_ACO]    = 1'b0;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ctrl  <= CTRL_RST;
      state <= ST_HIGH;
      saved <= ST_HIGH;
      err   <= 1'b0;
    end else begin
      ctrl  <= next_ctrl;
      state <= next_state;
      saved <= next_saved;
      err   <= next_err;
    end
  end

  // Registered clock enables and pin controls, no partial pulses
  lpmc_clk_t   next_clk;
  lpmc_state_t eff;
  logic        low_pwr, next_hold, next_clock_output_pin;

  always_comb begin
    low_pwr = (next_state == ST_WAIT) || (next_state == ST_STOP);
    eff     = low_pwr ? next_saved : next_state;
    next_clk.cpu_en     = !low_pwr;
    next_clk.periph_en  = (next_state != ST_STOP) && (eff != ST_LPWR) &&
                          !(next_state == ST_WAIT && next_ctrl[B_GATE]);
    next_clk.sub_osc    = (next_ctrl[B_SUBON] || eff == ST_LOW || eff == ST_LPWR) &&
                          (next_state != ST_STOP);
    next_clk.sub_tmr_en = next_clk.sub_osc;
    next_clk.main_osc   = (eff == ST_HIGH || eff == ST_LOW || eff == ST_PLL ||
                           eff == ST_RING) && (next_state != ST_STOP);
    next_clk.ring_osc   = (eff == ST_RING || eff == ST_RLP ||
                           (eff == ST_LOW && next_ctrl[B_RINGON])) &&
                          (next_state != ST_STOP);
    next_clk.pll_on     = next_ctrl[B_PLLEN] && (next_state != ST_STOP);
    if (eff == ST_LOW || eff == ST_LPWR) next_clk.cpu_src = SRC_SUB;
    else if (eff == ST_RING || eff == ST_RLP) next_clk.cpu_src = SRC_RING;
    else if (eff == ST_PLL) next_clk.cpu_src = SRC_PLL;
    else next_clk.cpu_src = SRC_MAIN;
    next_hold = low_pwr && next_ctrl[B_EXTBUS];
    if (next_state == ST_STOP) next_clock_output_pin = next_ctrl[B_COSUB] | clock_output_pin_o;
    else if (next_state == ST_WAIT && !next_ctrl[B_COSUB] && next_ctrl[B_GATE])
      next_clock_output_pin = clock_output_pin_o;
    else next_clock_output_pin = clk_src_s;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      clk_o         <= CLK_RST;
      div8_o        <= CTRL_RST[B_DIV8];
      div_sel_o     <= CTRL_RST[B_DIVLO+1:B_DIVLO];
      high_drive_o  <= CTRL_RST[B_HDRV];
      bus_hold_o    <= 1'b0;
      strobe_high_o <= 1'b0;
      clock_output_pin_o      <= 1'b0;
    end else begin
      clk_o         <= next_clk;
      div8_o        <= next_ctrl[B_DIV8];
      div_sel_o     <= next_ctrl[B_DIVLO+1:B_DIVLO];
      high_drive_o  <= next_ctrl[B_HDRV];
      bus_hold_o    <= next_hold;
      strobe_high_o <= next_hold;
      clock_output_pin_o      <= next_clock_output_pin;
    end
  end

  wait_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == ST_WAIT && ctrl[B_GATE]) |-> !clk_o.periph_en && !clk_o.cpu_en
      && (clk_o.sub_tmr_en == ctrl[B_SUBON] || saved == ST_LOW || saved == ST_LPWR))
    else $error("peripheral clocks running in gated wait");
  halt_enter_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (halt_i && state != ST_WAIT && state != ST_STOP && state != ST_PLL) |=>
      state == ST_WAIT && !clk_o.cpu_en && saved == $past(state))
    else $error("halt did not enter wait");
  bus_hold_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state inside {ST_WAIT, ST_STOP}) |-> (bus_hold_o == ctrl[B_EXTBUS]) && strobe_high_o == bus_hold_o)
    else $error("bus pins not held in wait or stop");
  wait_exit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == ST_WAIT && wait_wake) |=> state == $past(saved) && clk_o.cpu_en)
    else $error("wait exit did not restore mode");
  stop_enter_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (stop_req && !halt_i && state inside {ST_HIGH, ST_LOW, ST_LPWR, ST_RING, ST_RLP}) |=>
      state == ST_STOP && div8_o && high_drive_o && !clk_o.main_osc && !clk_o.ring_osc)
    else $error("stop entry did not force bits");
  stop_exit_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == ST_STOP && stop_wake) |=> div8_o && state != ST_STOP ##1 state != ST_PLL)
    else $error("stop exit without divide-by-eight");
  pll_guard_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == ST_PLL) |=> state inside {ST_PLL, ST_HIGH})
    else $error("illegal transition out of PLL mode");
  ring_guard_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state inside {ST_LOW, ST_LPWR}) |=> !(state inside {ST_RING, ST_RLP}))
    else $error("direct sub to ring transition");
  clock_output_pin_stop_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == ST_STOP && $past(state) == ST_STOP) |->
      (ctrl[B_COSUB] ? clock_output_pin_o : $stable(clock_output_pin_o)))
    else $error("clock output not held in stop");
  adc_gate_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == ST_WAIT && ctrl[B_GATE] && irq_i == 4'b0100 && pins_s == 3'b000) |=>
      state == ST_WAIT)
    else $error("converter woke gated wait");

endmodule : lpmc_top

// file: logic/lpmc_pkg.sv
// Shared constants, types and register layout of the power-mode controller.
// Assumes a single 250 MHz clock domain and an AXI4-Lite register master.
package lpmc_pkg;

  localparam int        ADDR_W      = 4;
  localparam int        CTRL_W      = 16;

  // Register byte addresses
  localparam logic [ADDR_W-1:0] CTRL_OFF = 4'h0;
  localparam logic [ADDR_W-1:0] MODE_OFF = 4'h4;
  localparam logic [ADDR_W-1:0] STAT_OFF = 4'h8;

  // Register select codes
  localparam logic [1:0] SEL_CTRL = 2'h0;
  localparam logic [1:0] SEL_MODE = 2'h1;
  localparam logic [1:0] SEL_STAT = 2'h2;
  localparam logic [1:0] SEL_NONE = 2'h3;

  // Control register bit positions
  localparam int B_GATE    = 0;   // periph_clock_gate_in_wait
  localparam int B_ACO     = 1;   // all_clocks_off, write one
  localparam int B_DIV8    = 2;   // divide_by_eight_select
  localparam int B_HDRV    = 3;   // main_osc_high_drive
  localparam int B_PLLSEL  = 4;   // pll_cpu_source_select, mirror
  localparam int B_PLLEN   = 5;   // pll_enable
  localparam int B_OSDE    = 6;   // osc_stop_detect_enable
  localparam int B_DIVLO   = 7;   // divider select, 2 bits
  localparam int B_EXTBUS  = 9;   // external bus mode
  localparam int B_COSUB   = 10;  // clock_output_pin shows sub_clock
  localparam int B_SUBON   = 11;  // sub oscillator on
  localparam int B_RINGON  = 12;  // ring oscillator on in low-speed
  localparam int B_ERR     = 4;   // status: refused request, write one clears

  localparam logic [CTRL_W-1:0] CTRL_RST   = 16'h0004;
  localparam logic [CTRL_W-1:0] CTRL_WMASK = 16'h1FED;

  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  localparam logic [1:0] SRC_MAIN = 2'h0;
  localparam logic [1:0] SRC_SUB  = 2'h1;
  localparam logic [1:0] SRC_RING = 2'h2;
  localparam logic [1:0] SRC_PLL  = 2'h3;

  typedef enum logic [2:0] {
    ST_HIGH = 3'b000,
    ST_LOW  = 3'b001,
    ST_LPWR = 3'b010,
    ST_PLL  = 3'b011,
    ST_RING = 3'b100,
    ST_RLP  = 3'b101,
    ST_WAIT = 3'b110,
    ST_STOP = 3'b111
  } lpmc_state_t;

  typedef struct packed {
    logic nmi;
    logic key;
    logic intp;
  } lpmc_pins_t;

  typedef struct packed {
    logic serial;
    logic adc;
    logic timer;
    logic can;
  } lpmc_periph_t;

  typedef struct packed {
    logic serial_ext;
    logic timer_event;
    logic timer_sub;
    logic adc_single;
  } lpmc_cfg_t;

  typedef struct packed {
    logic       cpu_en;
    logic       periph_en;
    logic       sub_tmr_en;
    logic       main_osc;
    logic       sub_osc;
    logic       ring_osc;
    logic       pll_on;
    logic [1:0] cpu_src;
  } lpmc_clk_t;

  // Reset enables equal the idle high-speed enables, so no edge follows reset
  localparam lpmc_clk_t CLK_RST = 9'h1A0;

endpackage : lpmc_pkg

// file: logic/lpmc_sync.sv
// Two-flop synchroniser for levels arriving from outside the clock domain.
// Assumes the source level is stable for at least two clock periods.
`timescale 1ns/100ps
module lpmc_sync import lpmc_pkg::*; #(
  parameter int W = 1
) (
  input  wire logic         clk_i,
  input  wire logic         rst_n_i,
  input  wire logic [W-1:0] d_i,
  output logic      [W-1:0] q_o
);

  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  always_comb begin
    next_meta = d_i;
    next_q    = meta;
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      q_o  <= '0;
    end else begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end

endmodule : lpmc_sync

// file: logic/lpmc_wake.sv
// Wake qualification for wait and stop modes.
// Assumes requests are already priority-qualified by the interrupt controller.
`timescale 1ns/100ps
module lpmc_wake import lpmc_pkg::*; (
  input  wire lpmc_pins_t   pins_i,
  input  wire lpmc_periph_t irq_i,
  input  wire lpmc_cfg_t    cfg_i,
  input  wire logic         gate_i,
  output logic              wait_wake_o,
  output logic              stop_wake_o
);

  logic always_on;
  logic ext_ser;
  logic ext_tmr;

  assign always_on = pins_i.nmi | pins_i.key | pins_i.intp | irq_i.can;
  assign ext_ser   = irq_i.serial & cfg_i.serial_ext;
  assign ext_tmr   = irq_i.timer & cfg_i.timer_event;

  // Gated clocks: only externally clocked sources, converter never
  assign wait_wake_o = always_on | (gate_i ?
                       (ext_ser | (irq_i.timer & (cfg_i.timer_event | cfg_i.timer_sub))) :
                       (irq_i.serial | irq_i.timer | (irq_i.adc & cfg_i.adc_single)));
  assign stop_wake_o = always_on | ext_ser | ext_tmr;

endmodule : lpmc_wake

// file: test/tb.sv
// Self-checking bench for the power-mode controller, register and mode sequences.
// Assumes the lpmc_pkg package and lpmc_top, with assertions inside the design.
`timescale 1ns/100ps
module tb import lpmc_pkg::*;;
  logic clk_i, rst_n_i, awvalid, wvalid, bready, arvalid, rready, halt_i, clock_output_pin_src_i;
  logic [ADDR_W-1:0] awaddr, araddr;
  logic [31:0]       wdata, rdata;
  logic [1:0]        bresp, rresp, div_sel;
  logic              awready, wready, bvalid, arready, rvalid;
  logic              div8, hdrv, bus_hold, strobe_high, clock_output_pin;
  lpmc_pins_t        pins_i;
  lpmc_periph_t      irq_i;
  lpmc_cfg_t         pcfg_i;
  lpmc_clk_t         clk_o;
  int                errors, total_checks;
  logic [31:0]       d;
  logic [1:0]        r;

  lpmc_top dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_awaddr_i(awaddr), .s_axi_wvalid_i(wvalid),
    .s_axi_wready_o(wready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hF),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_araddr_i(araddr),
    .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .halt_i(halt_i), .pins_i(pins_i), .irq_i(irq_i),
    .pcfg_i(pcfg_i), .clock_output_pin_src_i(clock_output_pin_src_i), .clk_o(clk_o), .div8_o(div8),
    .div_sel_o(div_sel), .high_drive_o(hdrv), .bus_hold_o(bus_hold),
    .strobe_high_o(strobe_high), .clock_output_pin_o(clock_output_pin));

  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : final_report

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] v);
    awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    r = bresp;
    bready <= 1'b0;
    @(posedge clk_i);
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk_i);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    d = rdata; r = rresp;
    rready <= 1'b0;
    @(posedge clk_i);
  endtask : rd

  task automatic do_halt();
    halt_i <= 1'b1;
    @(posedge clk_i);
    halt_i <= 1'b0;
    @(posedge clk_i);
  endtask : do_halt

  // Holds a request that must not wake, then checks the mode is unchanged
  task automatic no_wake(input logic [2:0] st);
    repeat (10) @(posedge clk_i);
    rd(MODE_OFF); chk(d, {29'h0, st});
  endtask : no_wake

  task automatic wake_wait();
    int n;
    n = 0;
    while (clk_o.cpu_en !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      n++;
    end
    chk(clk_o.cpu_en, 1'b1);
  endtask : wake_wait

  initial begin
    #40000;
    errors++;
    final_report();
  end

  initial begin
    errors = 0; total_checks = 0;
    rst_n_i = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; halt_i = 1'b0; clock_output_pin_src_i = 1'b1; awaddr = '0; araddr = '0;
    wdata = '0; pins_i = '0; irq_i = '0; pcfg_i = '0;
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    rd(CTRL_OFF); chk(d, 32'h0000_0004); chk(div8, 1'b1);
    chk(clk_o, 9'h1A0);
    rd(4'hC); chk(d, 32'h0000_0000); chk(r, RESP_SLVERR);
    wr(4'hC, 32'h0000_FFFF); chk(r, RESP_SLVERR);
    // Sub clock on, external bus, gating in wait, then low-speed mode
    wr(CTRL_OFF, 32'h0000_0B85); chk(r, RESP_OKAY); chk(div_sel, 2'h3);
    wr(MODE_OFF, 32'h0000_0001);
    rd(MODE_OFF); chk(d, 32'h0000_0001); chk(clk_o.cpu_src, SRC_SUB);
    do_halt(); chk(clk_o.cpu_en, 1'b0);
    chk(clk_o.periph_en, 1'b0); chk(clk_o.sub_tmr_en, 1'b1);
    chk(bus_hold, 1'b1); chk(strobe_high, 1'b1);
    rd(MODE_OFF); chk(d, 32'h0000_0006);
    pcfg_i <= 4'b0001; irq_i <= 4'b0100; clock_output_pin_src_i <= 1'b0;
    no_wake(3'h6);
    chk(clock_output_pin, 1'b1);
    irq_i <= 4'b0000; pcfg_i <= 4'b0100;
    @(posedge clk_i);
    irq_i <= 4'b0010;
    wake_wait();
    irq_i <= 4'b0000;
    chk(clk_o.cpu_src, SRC_SUB);
    rd(MODE_OFF); chk(d, 32'h0000_0001);
    wr(MODE_OFF, 32'h0000_0004); rd(STAT_OFF); chk(d, 32'h0000_0011);
    wr(STAT_OFF, 32'h0000_0010); rd(STAT_OFF); chk(d, 32'h0000_0001);
    // PLL mode, halt must be refused
    wr(MODE_OFF, 32'h0000_0000); wr(CTRL_OFF, 32'h0000_0220);
    wr(MODE_OFF, 32'h0000_0003); rd(CTRL_OFF); chk(d, 32'h0000_0230);
    do_halt(); rd(STAT_OFF); chk(d, 32'h0000_0013);
    wr(STAT_OFF, 32'h0000_0010); wr(MODE_OFF, 32'h0000_0000);
    // Stop from high-speed with undivided clock, clock output on sub clock
    wr(CTRL_OFF, 32'h0000_0402);
    chk(div8, 1'b1); chk(hdrv, 1'b1);
    chk(clock_output_pin, 1'b1);
    chk(clk_o.main_osc, 1'b0); chk(clk_o.cpu_en, 1'b0);
    chk({clk_o.sub_osc, clk_o.ring_osc, clk_o.pll_on}, 3'b000);
    chk(clk_o.periph_en, 1'b0);
    rd(MODE_OFF); chk(d, 32'h0000_0007);
    pcfg_i <= 4'b0001; irq_i <= 4'b0100;
    no_wake(3'h7);
    irq_i <= 4'b0000;
    @(posedge clk_i);
    irq_i <= 4'b0001;
    wake_wait();
    irq_i <= 4'b0000;
    chk(div8, 1'b1);
    chk(clk_o.cpu_src, SRC_MAIN);
    rd(MODE_OFF); chk(d, 32'h0000_0000);
    // Wait and stop ended by the non-maskable pin alone
    do_halt(); pins_i <= 3'b100;
    wake_wait(); pins_i <= 3'b000;
    chk(clk_o.cpu_src, SRC_MAIN);
    wr(CTRL_OFF, 32'h0000_0002); chk(r, RESP_OKAY);
    rd(MODE_OFF); chk(d, 32'h0000_0007);
    pins_i <= 3'b100;
    wake_wait(); pins_i <= 3'b000;
    chk(div8, 1'b1);
    rd(MODE_OFF); chk(d, 32'h0000_0000);
    final_report();
  end
endmodule : tb
